// File: core/tcsf_status.v
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "tcsf_map.vh"
module tcsf_status #(
  parameter CHANNEL = 1,
  parameter CW = 16
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // counter and event inputs
  input wire [CW-1:0] channel_counter,
  input wire count_up,
  input wire [CW-1:0] general_reg_c,
  input wire [CW-1:0] general_reg_d,
  input wire capture_c,
  input wire capture_d,
  // transfer controller acknowledges
  input wire xfer_ack_c,
  input wire xfer_ack_d,
  input wire transfer_disable_select,
  // interrupt requests
  output reg underflow_irq,
  output reg overflow_irq,
  output reg event_irq_c,
  output reg event_irq_d
);
  localparam FULL = (CHANNEL == 0) || (CHANNEL == 3);

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  reg [CW-1:0] prev_cnt;
  reg prev_valid;
  reg [5:2] irq_en;
  reg [2:0] mode;
  reg count_direction_flag;
  wire underflow_flag;
  wire overflow_flag;
  wire event_flag_c;
  wire event_flag_d;
  wire st_rd = rd && hit(addr, `TCSF_STATUS_OFS);
  wire st_wr = wr && hit(addr, `TCSF_STATUS_OFS);
  wire phase = mode[`TCSF_MODE_PHASE];

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_cnt <= `TCSF_CNT_MIN;
      prev_valid <= 1'b0;
      count_direction_flag <= `TCSF_DIR_RST;
      irq_en <= 4'h0;
      mode <= 3'h0;
    end else begin
      prev_cnt <= channel_counter;
      prev_valid <= 1'b1;
      count_direction_flag <= count_up;
      if (wr && hit(addr, `TCSF_ENABLE_OFS)) begin
        irq_en <= wdata[5:2];
      end
      if (wr && hit(addr, `TCSF_MODE_OFS)) begin
        mode <= wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // underflow, overflow and compare/capture event detect, plus transfer-ack hardware clears
  wire unf_evt = !FULL && phase && prev_valid && prev_cnt == `TCSF_CNT_MIN
    && channel_counter == `TCSF_CNT_MAX;
  wire ovf_evt = prev_valid && prev_cnt == `TCSF_CNT_MAX && channel_counter == `TCSF_CNT_MIN;
  wire evd_evt = FULL && (mode[`TCSF_MODE_D_CAPT] ? capture_d
    : (channel_counter == general_reg_d));
  wire evc_evt = FULL && (mode[`TCSF_MODE_C_CAPT] ? capture_c
    : (channel_counter == general_reg_c));
  wire hwc_d = xfer_ack_d && !transfer_disable_select;
  wire hwc_c = xfer_ack_c && !transfer_disable_select;

  tcsf_flag u_unf (
    .mclk(mclk), .resetn(resetn), .set_evt(unf_evt), .hw_clear(1'b0),
    .sw_read(st_rd), .sw_write(st_wr), .sw_data(wdata[`TCSF_BIT_UNF]),
    .flag(underflow_flag)
  );
  tcsf_flag u_ovf (
    .mclk(mclk), .resetn(resetn), .set_evt(ovf_evt), .hw_clear(1'b0),
    .sw_read(st_rd), .sw_write(st_wr), .sw_data(wdata[`TCSF_BIT_OVF]),
    .flag(overflow_flag)
  );
  tcsf_flag u_evd (
    .mclk(mclk), .resetn(resetn), .set_evt(evd_evt), .hw_clear(hwc_d),
    .sw_read(st_rd), .sw_write(st_wr), .sw_data(wdata[`TCSF_BIT_EVD]),
    .flag(event_flag_d)
  );
  tcsf_flag u_evc (
    .mclk(mclk), .resetn(resetn), .set_evt(evc_evt), .hw_clear(hwc_c),
    .sw_read(st_rd), .sw_write(st_wr), .sw_data(wdata[`TCSF_BIT_EVC]),
    .flag(event_flag_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  reg [7:0] status_view;
  always @* begin
    status_view = 8'h00;
    status_view[`TCSF_BIT_DIR] = FULL ? 1'b1 : count_direction_flag;
    status_view[`TCSF_BIT_RSV6] = 1'b1;
    status_view[`TCSF_BIT_UNF] = FULL ? 1'b0 : underflow_flag;
    status_view[`TCSF_BIT_OVF] = overflow_flag;
    status_view[`TCSF_BIT_EVD] = FULL ? event_flag_d : 1'b0;
    status_view[`TCSF_BIT_EVC] = FULL ? event_flag_c : 1'b0;
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
      underflow_irq <= 1'b0;
      overflow_irq <= 1'b0;
      event_irq_c <= 1'b0;
      event_irq_d <= 1'b0;
    end else begin
      if (rd && hit(addr, `TCSF_STATUS_OFS)) begin
        rdata <= status_view;
      end else if (rd && hit(addr, `TCSF_ENABLE_OFS)) begin
        rdata <= {2'b00, irq_en, 2'b00};
      end else if (rd && hit(addr, `TCSF_MODE_OFS)) begin
        rdata <= {5'h00, mode};
      end else begin
        rdata <= 8'h00;
      end
      underflow_irq <= status_view[`TCSF_BIT_UNF] && irq_en[`TCSF_EN_UNF];
      overflow_irq <= overflow_flag && irq_en[`TCSF_EN_OVF];
      event_irq_d <= status_view[`TCSF_BIT_EVD] && irq_en[`TCSF_EN_EVD];
      event_irq_c <= status_view[`TCSF_BIT_EVC] && irq_en[`TCSF_EN_EVC];
    end
  end
endmodule // tcsf_status

// File: core/tcsf_map.vh
`ifndef TCSF_MAP_VH
`define TCSF_MAP_VH
// register offsets (byte addresses on the local port)
`define TCSF_STATUS_OFS 8'h00
`define TCSF_ENABLE_OFS 8'h04
`define TCSF_MODE_OFS 8'h08
// status bit positions
`define TCSF_BIT_DIR 7
`define TCSF_BIT_RSV6 6
`define TCSF_BIT_UNF 5
`define TCSF_BIT_OVF 4
`define TCSF_BIT_EVD 3
`define TCSF_BIT_EVC 2
// enable register bit positions
`define TCSF_EN_UNF 5
`define TCSF_EN_OVF 4
`define TCSF_EN_EVD 3
`define TCSF_EN_EVC 2
// mode register bit positions
`define TCSF_MODE_PHASE 0
`define TCSF_MODE_D_CAPT 1
`define TCSF_MODE_C_CAPT 2
// counter boundary values
`define TCSF_CNT_MIN 16'h0000
`define TCSF_CNT_MAX 16'hFFFF
// reset values
`define TCSF_STATUS_RST 8'hC0
`define TCSF_DIR_RST 1'b1
`endif

// File: core/tcsf_flag.v
`timescale 1ns/100ps
// one sticky event flag with read-armed software clear
module tcsf_flag (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // events
  input wire set_evt,
  input wire hw_clear,
  input wire sw_read,
  input wire sw_write,
  input wire sw_data,
  // state
  output reg flag
);
  reg armed;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (set_evt) begin
        flag <= 1'b1;
      end else if (hw_clear) begin
        flag <= 1'b0;
      end else if (sw_write && !sw_data && armed) begin
        flag <= 1'b0;
      end
      if (set_evt || !flag || (sw_write && !sw_data && armed)) begin
        armed <= 1'b0;
      end else if (sw_read) begin
        armed <= 1'b1;
      end
    end
  end
endmodule // tcsf_flag

// File: tb/tcsf_status_chk.sv
`timescale 1ns/100ps
module tcsf_status_chk (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // counter and compare
  input wire [15:0] channel_counter,
  input wire [15:0] general_reg_c
);
  wire rs = rd && addr == 8'h00;
  wire wz = wr && addr == 8'h00;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  reset_read_a:
    assert property (!$past(resetn) && rs |=> rdata == 8'hC0) else $error("reset value");
  fixed_six_a:
    assert property (rs |=> rdata[6]) else $error("bit 6");
  fixed_dir_a:
    assert property (rs |=> rdata[7]) else $error("bit 7");
  rsv_five_a:
    assert property (rs |=> !rdata[5]) else $error("bit 5");
  ovf_set_a:
    assert property ($past(channel_counter) == 16'hFFFF && channel_counter == 16'h0000
      ##1 rs |=> rdata[4]) else $error("overflow set");
  ovf_clear_a:
    assert property (rs && $stable(channel_counter) ##1 rdata[4] && $stable(channel_counter)
      ##1 wz && !wdata[4] && $stable(channel_counter) ##1 rs && $stable(channel_counter)
      |=> !rdata[4]) else $error("overflow clear");
  write_one_a:
    assert property (rs && $stable(channel_counter) ##1 !rdata[4] && $stable(channel_counter)
      ##1 wz && wdata[4] && $stable(channel_counter) ##1 rs && $stable(channel_counter)
      |=> !rdata[4]) else $error("write one");
  cmp_c_a:
    assert property (channel_counter == general_reg_c ##1 rs |=> rdata[2]) else $error("flag c");
endmodule // tcsf_status_chk
bind tcsf_status tcsf_status_chk chk (.*);

// File: tb/test_tcsf_status.sv
`timescale 1ns/100ps
module test_tcsf_status;
  reg mclk = 0, resetn = 0, wr = 0, rd = 0, count_up = 1, capture_c = 0, capture_d = 0;
  reg xfer_ack_c = 0, xfer_ack_d = 0, transfer_disable_select = 1;
  reg [7:0] addr = 8'h00, wdata = 8'h00;
  reg [15:0] channel_counter = 16'h0000, general_reg_c = 16'hFFFE, general_reg_d = 16'hFFFE;
  wire [7:0] rdata;
  wire underflow_irq, overflow_irq, event_irq_c, event_irq_d;
  int miscompares = 0, comparisons = 0, m = 0, arm = 0, v;
  always #2 mclk = ~mclk;
  tcsf_status #(.CHANNEL(0), .CW(16)) dut (.*);
  task chk(input string n, input [7:0] e, input [7:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rdc(input [7:0] a);
    addr <= a;
    rd <= 1;
    @(posedge mclk) rd <= 0;
    @(negedge mclk) chk("rdata", a == 8'h00 ? 8'hC0 | m[7:0] : 8'h00, rdata);
    if (a == 8'h00) arm = m;
    @(posedge mclk);
  endtask
  task wrt(input [7:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk) wr <= 0;
    if (a == 8'h00) m = m & ~(arm & ~d & 8'h3C);
  endtask
  task sf(input int b);
    m = m | b;
    arm = arm & ~b;
  endtask
  task wrap;
    channel_counter <= 16'hFFFF;
    @(posedge mclk) channel_counter <= 16'h0000;
    @(posedge mclk) sf(8'h10);
  endtask
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    v = $urandom(87);
    repeat (10) @(posedge mclk);
    resetn <= 1;
    rdc(8'h00);
    wrt(8'h00, 8'hFF);
    rdc(8'h00);
    rdc(8'hFC);
    wrt(8'h04, 8'h10);
    wrap();
    rdc(8'h00);
    @(negedge mclk) chk("overflow_irq", 8'h01, {7'h00, overflow_irq});
    @(posedge mclk) wrap();
    wrt(8'h00, 8'h00);
    rdc(8'h00);
    wrt(8'h00, 8'hEF);
    rdc(8'h00);
    general_reg_c <= 16'h0000;
    @(posedge mclk) general_reg_c <= 16'hFFFE;
    sf(8'h04);
    rdc(8'h00);
    xfer_ack_c <= 1;
    @(posedge mclk) xfer_ack_c <= 0;
    rdc(8'h00);
    transfer_disable_select <= 0;
    xfer_ack_c <= 1;
    @(posedge mclk) xfer_ack_c <= 0;
    m = m & ~8'h04;
    rdc(8'h00);
    v = 1 + $urandom % 65532;
    general_reg_d <= v[15:0];
    channel_counter <= v[15:0];
    @(posedge mclk) channel_counter <= v[15:0] + 16'h0001;
    sf(8'h08);
    @(posedge mclk) channel_counter <= 16'h0000;
    rdc(8'h00);
    wrt(8'h00, 8'h00);
    rdc(8'h00);
    wrt(8'h08, 8'h02);
    capture_d <= 1;
    @(posedge mclk) capture_d <= 0;
    sf(8'h08);
    rdc(8'h00);
    xfer_ack_d <= 1;
    @(posedge mclk) xfer_ack_d <= 0;
    m = 0;
    rdc(8'h00);
    finish_test();
  end
endmodule // test_tcsf_status
